// >>> logic/mgmt_pkg.sv
package mgmt_pkg;
    // Frame layout.
    localparam int PREAMBLE_BITS   = 32;
    localparam int HEADER_BITS     = 14;
    localparam int DATA_BITS       = 16;
    localparam logic [1:0] START_PATTERN = 2'h1;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [1:0] TURN_WRITE    = 2'h2;
    localparam logic [4:0] BROADCAST_ADDR = 5'h00;

    // Register offsets.
    localparam logic [4:0] REG_BASIC_CONTROL    = 5'h00;
    localparam logic [4:0] REG_PHY_CONTROL_ONE  = 5'h16;
    localparam logic [4:0] REG_INTERRUPT_CS     = 5'h1b;
    localparam logic [4:0] REG_CABLE_DIAGNOSTIC = 5'h1d;
    localparam logic [4:0] REG_PHY_CONTROL_TWO  = 5'h1f;

    // Field positions.
    localparam int BC_LOOPBACK     = 14;
    localparam int BC_SPEED        = 13;
    localparam int BC_AUTONEG      = 12;
    localparam int BC_DUPLEX       = 8;
    localparam int P1_BCAST_OFF    = 9;
    localparam int P2_MDIX_FORCE   = 14;
    localparam int P2_AUTOX_OFF    = 13;
    localparam int P2_IRQ_HIGH     = 9;
    localparam int P2_REMOTE_LOOP  = 2;
    localparam int CD_START        = 15;

    // Reset values.
    localparam logic [15:0] BASIC_CONTROL_RST = 16'h3100;
    localparam logic [15:0] PHY_CONTROL_RST   = 16'h0000;

    // Cable test results.
    localparam logic [1:0] CABLE_NORMAL  = 2'h0;
    localparam logic [1:0] CABLE_OPEN    = 2'h1;
    localparam logic [1:0] CABLE_SHORT   = 2'h2;
    localparam logic [1:0] CABLE_INVALID = 2'h3;

    // Timing at 40 MHz.
    localparam int CLK_PERIOD_NS   = 25;
    localparam int MDC_MIN_NS      = 100;
    localparam int MDC_HALF_CYCLES = (MDC_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CABLE_TEST_CYCLES = 64;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_HEADER = 3'h1,
        ST_TURN   = 3'h2,
        ST_DATA   = 3'h3,
        ST_SKIP   = 3'h4
    } frame_state_t;
endpackage

// >>> logic/mgmt_if.sv
`timescale 1ns/10ps
interface mgmt_if;
    logic mdc;
    logic hostDataOut;
    logic hostDataOe;
    logic phyDataOut;
    logic phyDataOe;
    wire  mdio = hostDataOe ? hostDataOut : (phyDataOe ? phyDataOut : 1'b1);

    modport phy  (input mdc, input mdio, output phyDataOut, output phyDataOe);
    modport host (output mdc, input mdio, output hostDataOut, output hostDataOe);
endinterface

// >>> logic/phy_mgmt_slave.sv
`timescale 1ns/10ps
// How it works
// - Answer own address and broadcast zero.
// - Strap or control bit disables broadcast.
// - Own address comes from sampled straps.
// - Management clock stays at or below 10MHz.
// - Preamble, start, opcode, addresses in order.
// - Turnaround then sixteen data bits, then release.
// - Five-bit register address, thirty-two registers; five are decoded here, the rest read zero.
// - Upper interrupt bits enable conditions.
// - Lower interrupt bits sticky, cleared by read.
// - Interrupt polarity selectable, active low default.
// - Auto crossover on by default, bit disables.
// - Manual bit forces straight or crossed.
// - Auto mode follows partner pair usage.
// - Straight sends pair one, crossed swaps.
// - Local loopback set through basic control.
// - Local loopback returns MAC frames inward.
// - Remote loopback only at 100 full.
// - Software disables auto crossover before testing.
// - Start bit runs test, clears itself.
// - Result code reports normal, open, short, invalid.
// - Partner not silenced gives invalid code.
// - Nine-bit delay count reports fault distance.
module phy_mgmt_slave
    import mgmt_pkg::*;
#(
    parameter int TEST_CYCLES = CABLE_TEST_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Management pins
    mgmt_if.phy              mgmt,
    // Straps
    input  wire logic [2:0]  address_straps,
    input  wire logic        broadcast_disable_strap,
    // Events and line status
    input  wire logic [7:0]  irqEvents,
    input  wire logic        partnerUsesMdix,
    input  wire logic        linkUp,
    input  wire logic        partnerSilenced,
    input  wire logic [1:0]  cableFault,
    input  wire logic [8:0]  cableDelay,
    // Outputs
    output logic             irq_out,
    output logic             pairCrossed,
    output logic             localLoopback,
    output logic             localLoopToCopper,
    output logic             remoteLoopback,
    output logic             speed100,
    output logic             fullDuplex,
    output logic             autoNegEnable,
    output logic             cableTestRunning
);
    import mgmt_pkg::*;

    localparam bit MII_VARIANT = 1'b1;

    logic [1:0]  mdcSync;
    logic [1:0]  dataSync;
    logic        mdcLast;
    logic [2:0]  ownAddr;
    logic        bcastStrap;
    logic        strapTaken;
    frame_state_t state;
    logic [5:0]  bitCount;
    logic [15:0] shiftIn;
    logic [15:0] shiftOut;
    logic        isRead;
    logic        selected;
    logic [4:0]  regAddr;
    logic [15:0] basicControl;
    logic [15:0] phyControlOne;
    logic [15:0] phyControlTwo;
    logic [7:0]  irqEnable;
    logic [7:0]  irqStatus;
    logic [1:0]  cableResult;
    logic [8:0]  cableCount;
    logic [15:0] testTimer;
    logic        dataOut;
    logic        dataOe;

    wire mdcRise = mdcSync[1] & ~mdcLast;
    wire mdcFall = ~mdcSync[1] & mdcLast;
    wire inBit   = dataSync[1];
    wire bcastOff   = bcastStrap | phyControlOne[P1_BCAST_OFF];
    wire [4:0] hdrPhy = shiftIn[8:4];
    wire addrHit = (hdrPhy == {2'h0, ownAddr}) | (hdrPhy == BROADCAST_ADDR & ~bcastOff);
    wire [1:0] hdrOp = shiftIn[10:9];
    wire hdrOk   = shiftIn[12:11] == START_PATTERN & (hdrOp == OP_READ | hdrOp == OP_WRITE);
    wire irqActive = |(irqEnable & irqStatus);
    wire writeDone = state == ST_DATA & mdcRise & bitCount == 6'(DATA_BITS - 1) & ~isRead & selected;
    wire readStart = state == ST_TURN & mdcRise & bitCount == 6'h1 & isRead & selected;
    wire isrRead   = readStart & regAddr == REG_INTERRUPT_CS;
    wire [15:0] writeData = {shiftIn[14:0], inBit};
    wire testStart = writeDone & regAddr == REG_CABLE_DIAGNOSTIC & writeData[CD_START];
    wire autoX     = ~phyControlTwo[P2_AUTOX_OFF];

    function automatic logic [15:0] readMux(input logic [4:0] a);
        case (a)
            REG_BASIC_CONTROL:    readMux = basicControl;
            REG_PHY_CONTROL_ONE:  readMux = phyControlOne;
            REG_INTERRUPT_CS:     readMux = {irqEnable, irqStatus};
            REG_CABLE_DIAGNOSTIC: readMux = {cableTestRunning, cableResult, 4'h0, cableCount};
            REG_PHY_CONTROL_TWO:  readMux = phyControlTwo;
            default:              readMux = 16'h0000;
        endcase
    endfunction

    // Both line inputs pass two flops; edges are found on the second stage only.
    always_ff @(posedge clk) begin
        mdcSync  <= {mdcSync[0], mgmt.mdc};
        dataSync <= {dataSync[0], mgmt.mdio};
        mdcLast  <= mdcSync[1];
    end

    // Straps are caught on the first clock after reset release.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strapTaken <= 1'b0;
            ownAddr    <= 3'h0;
            bcastStrap <= 1'b0;
        end else if (!strapTaken) begin
            strapTaken <= 1'b1;
            ownAddr    <= address_straps;
            bcastStrap <= broadcast_disable_strap;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state    <= ST_IDLE;
            bitCount <= 6'h0;
            shiftIn  <= 16'h0000;
            isRead   <= 1'b0;
            selected <= 1'b0;
            regAddr  <= 5'h00;
        end else if (mdcRise) begin
            shiftIn <= {shiftIn[14:0], inBit};
            case (state)
                ST_IDLE: begin
                    bitCount <= inBit ? ((bitCount == 6'(PREAMBLE_BITS)) ? bitCount : bitCount + 6'h1) : 6'h0;
                    if (!inBit && bitCount == 6'(PREAMBLE_BITS)) begin
                        state    <= ST_HEADER;
                        bitCount <= 6'h1;
                    end
                end
                ST_HEADER: begin
                    bitCount <= bitCount + 6'h1;
                    if (bitCount == 6'(HEADER_BITS - 1)) begin
                        isRead   <= hdrOp == OP_READ;
                        selected <= hdrOk & addrHit;
                        regAddr  <= {shiftIn[3:0], inBit};
                        bitCount <= 6'h0;
                        state    <= hdrOk ? ST_TURN : ST_SKIP;
                    end
                end
                ST_TURN: begin
                    bitCount <= bitCount + 6'h1;
                    if (bitCount == 6'h1) begin
                        bitCount <= 6'h0;
                        state    <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    bitCount <= bitCount + 6'h1;
                    if (bitCount == 6'(DATA_BITS - 1)) begin
                        bitCount <= 6'h0;
                        state    <= ST_IDLE;
                    end
                end
                ST_SKIP: begin
                    bitCount <= 6'h0;
                    state    <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Read data: the zero turnaround bit is driven after the first turnaround rising edge, then sixteen bits.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dataOe   <= 1'b0;
            dataOut  <= 1'b1;
            shiftOut <= 16'h0000;
        end else begin
            if (state == ST_TURN && bitCount == 6'h0 && isRead && selected && mdcRise) begin
                dataOe   <= 1'b1;
                dataOut  <= 1'b0;
                shiftOut <= readMux(regAddr);
            end else if (readStart) begin
                dataOut  <= shiftOut[15];
                shiftOut <= {shiftOut[14:0], 1'b0};
            end else if (state == ST_DATA && mdcRise && isRead && selected) begin
                if (bitCount == 6'(DATA_BITS - 1)) begin
                    dataOe  <= 1'b0;
                    dataOut <= 1'b1;
                end else begin
                    dataOut  <= shiftOut[15];
                    shiftOut <= {shiftOut[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            basicControl  <= BASIC_CONTROL_RST;
            phyControlOne <= PHY_CONTROL_RST;
            phyControlTwo <= PHY_CONTROL_RST;
            irqEnable     <= 8'h00;
        end else if (writeDone) begin
            case (regAddr)
                REG_BASIC_CONTROL:   basicControl  <= writeData;
                REG_PHY_CONTROL_ONE: phyControlOne <= writeData;
                REG_INTERRUPT_CS:    irqEnable     <= writeData[15:8];
                REG_PHY_CONTROL_TWO: phyControlTwo <= writeData;
                default: ;
            endcase
        end
    end

    // A new event in the clearing cycle survives the read.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStatus <= 8'h00;
        end else begin
            irqStatus <= (isrRead ? 8'h00 : irqStatus) | irqEvents;
        end
    end

    // The reflectometry front end is outside; this counts the test window and latches its answer.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cableTestRunning <= 1'b0;
            testTimer        <= 16'h0000;
            cableResult      <= CABLE_NORMAL;
            cableCount       <= 9'h000;
        end else if (testStart && !cableTestRunning) begin
            cableTestRunning <= 1'b1;
            testTimer        <= 16'(TEST_CYCLES);
        end else if (cableTestRunning) begin
            testTimer <= testTimer - 16'h1;
            if (!partnerSilenced) begin
                cableTestRunning <= 1'b0;
                cableResult      <= CABLE_INVALID;
                cableCount       <= 9'h000;
            end else if (testTimer == 16'h1) begin
                cableTestRunning <= 1'b0;
                cableResult      <= cableFault;
                cableCount       <= cableDelay;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_out     <= 1'b1;
            pairCrossed <= 1'b0;
        end else begin
            irq_out     <= phyControlTwo[P2_IRQ_HIGH] ? irqActive : ~irqActive;
            pairCrossed <= autoX ? partnerUsesMdix : phyControlTwo[P2_MDIX_FORCE];
        end
    end

    assign speed100          = basicControl[BC_SPEED];
    assign fullDuplex        = basicControl[BC_DUPLEX];
    assign autoNegEnable     = basicControl[BC_AUTONEG];
    assign localLoopback     = basicControl[BC_LOOPBACK];
    assign localLoopToCopper = localLoopback & MII_VARIANT;
    assign remoteLoopback    = phyControlTwo[P2_REMOTE_LOOP] & linkUp & speed100 & fullDuplex;
    assign mgmt.phyDataOut   = dataOut;
    assign mgmt.phyDataOe    = dataOe;
endmodule

// >>> logic/mgmt_host.sv
`timescale 1ns/10ps
module mgmt_host
    import mgmt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Management pins
    mgmt_if.host             mgmt,
    // Software port
    input  wire logic [1:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata
);
    import mgmt_pkg::*;

    // Software registers: command at 0, status at 1.
    localparam logic [1:0] HOST_CMD    = 2'h0;
    localparam logic [1:0] HOST_STATUS = 2'h1;
    localparam int FRAME_BITS = PREAMBLE_BITS + HEADER_BITS + 2 + DATA_BITS;

    logic [63:0] frameOut;
    logic [6:0]  bitsLeft;
    logic        busy;
    logic        readOp;
    logic [15:0] readData;
    logic [15:0] divCount;
    logic        mdcReg;
    logic        oe;
    logic [1:0]  inSync;

    wire start  = wr & addr == HOST_CMD & ~busy;
    wire halfUp = divCount == 16'(MDC_HALF_CYCLES - 1);
    // A read frame gives up the line from the turnaround onward.
    wire releaseNow = readOp & bitsLeft == 7'(DATA_BITS + 3);
    wire [31:0] next_rdata = (addr == HOST_STATUS) ? {15'h0, busy, readData} : 32'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) inSync <= 2'h0;
        else         inSync <= {inSync[0], mgmt.mdio};
    end

    // The clock is divided down to at most 10MHz; data changes on the falling half.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy     <= 1'b0;
            divCount <= 16'h0;
            mdcReg   <= 1'b0;
            oe       <= 1'b0;
            bitsLeft <= 7'h0;
            frameOut <= 64'h0;
            readOp   <= 1'b0;
            readData <= 16'h0;
        end else if (start) begin
            busy     <= 1'b1;
            readOp   <= wdata[17:16] == OP_READ;
            frameOut <= {32'hffffffff, START_PATTERN, wdata[17:16], wdata[30:26], wdata[25:21], TURN_WRITE,
                         wdata[15:0]};
            bitsLeft <= 7'(FRAME_BITS);
            divCount <= 16'h0;
            mdcReg   <= 1'b0;
            oe       <= 1'b1;
        end else if (busy) begin
            divCount <= halfUp ? 16'h0 : divCount + 16'h1;
            if (halfUp) begin
                mdcReg <= ~mdcReg;
                if (mdcReg) begin
                    // The device answers three clocks after a rising edge and this side syncs in two more,
                    // so its bit is taken half a period late, at the following falling edge.
                    if (readOp && bitsLeft <= 7'(DATA_BITS)) begin
                        readData <= {readData[14:0], inSync[1]};
                    end
                    frameOut <= {frameOut[62:0], 1'b0};
                    bitsLeft <= bitsLeft - 7'h1;
                    if (releaseNow || bitsLeft == 7'h1) oe <= 1'b0;
                    if (bitsLeft == 7'h1) busy <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) rdata <= 32'h0;
        else if (rd) rdata <= next_rdata;
        else         rdata <= 32'h0;
    end

    assign mgmt.mdc         = mdcReg;
    assign mgmt.hostDataOut = frameOut[FRAME_BITS - 1];
    assign mgmt.hostDataOe  = oe;
endmodule

// >>> tb/mgmt_wire_sva.sv
`timescale 1ns/10ps
module mgmt_wire_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Management wire
    input wire logic mdc,
    input wire logic mdio,
    input wire logic hostDataOut,
    input wire logic hostDataOe,
    input wire logic phyDataOut,
    input wire logic phyDataOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // A read answer is seventeen bit times of four clocks each, so a stuck enable shows up early.
    logic [7:0] oeCount;
    always_ff @(posedge clk) begin
        if (sys_rst || !phyDataOe) oeCount <= 8'h00;
        else if (oeCount != 8'hff) oeCount <= oeCount + 8'h01;
    end

    a_no_contention: assert property (!(hostDataOe && phyDataOe))
        else $error("both ends drive the data line");
    a_host_setup_held: assert property ($rose(mdc) |-> $stable(hostDataOut))
        else $error("host data moved at the sampling edge");
    a_phy_setup_held: assert property ($rose(mdc) && phyDataOe |-> $stable(phyDataOut))
        else $error("device data moved at the sampling edge");
    a_mdc_high_min: assert property ($rose(mdc) |=> mdc)
        else $error("management clock high too short");
    a_mdc_low_min: assert property ($fell(mdc) |=> !mdc)
        else $error("management clock low too short");
    a_turn_zero: assert property ($rose(phyDataOe) |-> !mdio && !phyDataOut)
        else $error("turnaround bit not zero");
    a_turn_released: assert property ($rose(phyDataOe) |-> !$past(hostDataOe))
        else $error("device drove before host released");
    a_answer_length: assert property (oeCount <= 8'h48)
        else $error("device held the line too long");
    a_preamble_one: assert property ($rose(hostDataOe) |-> hostDataOut)
        else $error("frame did not open with a one");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !phyDataOe && !hostDataOe)
        else $error("line driven out of reset");

    c_read_answer: cover property ($rose(phyDataOe));
    c_frame_start: cover property ($rose(hostDataOe));
    c_answer_done: cover property ($fell(phyDataOe));
endmodule

// >>> tb/phy_mdio_mgmt_and_diag_ctrl_tb_top.sv
`timescale 1ns/10ps
module phy_mdio_mgmt_and_diag_ctrl_tb_top;
    import mgmt_pkg::*;
    localparam logic [4:0] ME = 5'h03;
    logic        clk;
    logic        sys_rst;
    logic [1:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [7:0]  irqEvents;
    logic        partnerUsesMdix;
    logic        partnerSilenced;
    logic [1:0]  cableFault;
    logic [8:0]  cableDelay;
    logic        irqOut;
    logic        pairCrossed;
    logic        localLoop;
    logic        loopToCopper;
    logic        remoteLoop;
    logic        speed100;
    logic        fullDuplex;
    logic        autoNeg;
    logic        testRunning;
    logic [15:0] q;
    logic [31:0] stw;
    int          n_fail = 0;
    int          cmp_count = 0;

    mgmt_if mgmt_if_inst ();
    // A long test window keeps the running bit visible across one whole read frame.
    phy_mgmt_slave #(.TEST_CYCLES(400)) phy_mgmt_slave_inst (
        .clk(clk), .sys_rst(sys_rst), .mgmt(mgmt_if_inst.phy), .address_straps(3'h3),
        .broadcast_disable_strap(1'b0), .irqEvents(irqEvents), .partnerUsesMdix(partnerUsesMdix),
        .linkUp(1'b1), .partnerSilenced(partnerSilenced), .cableFault(cableFault), .cableDelay(cableDelay),
        .irq_out(irqOut), .pairCrossed(pairCrossed), .localLoopback(localLoop), .localLoopToCopper(loopToCopper),
        .remoteLoopback(remoteLoop), .speed100(speed100), .fullDuplex(fullDuplex), .autoNegEnable(autoNeg),
        .cableTestRunning(testRunning));
    mgmt_host mgmt_host_inst (.clk(clk), .sys_rst(sys_rst), .mgmt(mgmt_if_inst.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    mgmt_wire_sva mgmt_wire_sva_inst (.clk(clk), .sys_rst(sys_rst), .mdc(mgmt_if_inst.mdc),
        .mdio(mgmt_if_inst.mdio), .hostDataOut(mgmt_if_inst.hostDataOut), .hostDataOe(mgmt_if_inst.hostDataOe),
        .phyDataOut(mgmt_if_inst.phyDataOut), .phyDataOe(mgmt_if_inst.phyDataOe));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sw_wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic sw_rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Issues one frame and polls the busy flag; read data come from the status word.
    task automatic frame(input logic [4:0] phy, input logic [4:0] rg, input logic [1:0] op,
                         input logic [15:0] d, output logic [15:0] res);
        logic [31:0] st;
        int          n;
        sw_wr(2'h0, {1'b0, phy, rg, 3'h0, op, d});
        n = 0;
        st = 32'h0001_0000;
        while (st[16] !== 1'b0 && n < 1000) begin
            sw_rd(2'h1, st);
            n++;
        end
        if (n >= 1000) begin
            n_fail++;
            final_report();
        end
        res = st[15:0];
        repeat (4) @(posedge clk);
    endtask

    task automatic rchk(input string what, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp);
        logic [15:0] r;
        frame(phy, rg, OP_READ, 16'h0000, r);
        chk(what, exp, r);
    endtask

    task automatic wreg(input logic [4:0] rg, input logic [15:0] d);
        logic [15:0] r;
        frame(ME, rg, OP_WRITE, d, r);
    endtask

    task automatic pulse(input logic [7:0] ev);
        @(posedge clk);
        irqEvents <= ev;
        @(posedge clk);
        irqEvents <= 8'h00;
        repeat (4) @(posedge clk);
    endtask

    task automatic cable_run(input logic [15:0] exp, input logic [15:0] mask, input logic run);
        int n;
        wreg(REG_CABLE_DIAGNOSTIC, 16'h8000);
        chk("testRunning", {15'h0, run}, {15'h0, testRunning});
        n = 0;
        q = 16'h8000;
        while (q[15] !== 1'b0 && n < 20) begin
            frame(ME, REG_CABLE_DIAGNOSTIC, OP_READ, 16'h0000, q);
            n++;
        end
        chk("cableResult", exp, q & mask);
    endtask

    initial begin
        sys_rst = 1'b1;
        addr = 2'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        irqEvents = 8'h00;
        partnerUsesMdix = 1'b1;
        partnerSilenced = 1'b1;
        cableFault = 2'h0;
        cableDelay = 9'h000;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irqIdle", 16'h0001, {15'h0, irqOut});
        rchk("basicReset", ME, REG_BASIC_CONTROL, BASIC_CONTROL_RST);
        rchk("broadcastRead", BROADCAST_ADDR, REG_BASIC_CONTROL, BASIC_CONTROL_RST);
        rchk("otherAddr", 5'h05, REG_BASIC_CONTROL, 16'hffff);
        rchk("ctrlTwoReset", ME, REG_PHY_CONTROL_TWO, PHY_CONTROL_RST);
        chk("autoCross", 16'h0001, {15'h0, pairCrossed});
        sw_wr(2'h2, 32'h0c20_0000);
        sw_rd(2'h1, stw);
        chk("unmappedIdle", 16'h0000, {15'h0, stw[16]});
        wreg(REG_BASIC_CONTROL, 16'h6100);
        chk("loopFlags", 16'h001d, {11'h0, localLoop, loopToCopper, speed100, autoNeg, fullDuplex});
        wreg(REG_PHY_CONTROL_TWO, 16'h0004);
        chk("remoteOn", 16'h0001, {15'h0, remoteLoop});
        wreg(REG_BASIC_CONTROL, 16'h4100);
        chk("remoteTenMbps", 16'h0000, {15'h0, remoteLoop});
        wreg(REG_PHY_CONTROL_TWO, 16'h2000);
        chk("forceStraight", 16'h0000, {15'h0, pairCrossed});
        wreg(REG_PHY_CONTROL_TWO, 16'h6000);
        partnerUsesMdix <= 1'b0;
        repeat (4) @(posedge clk);
        chk("forceCrossed", 16'h0001, {15'h0, pairCrossed});
        for (int f = 0; f < 3; f++) begin
            cableFault <= f[1:0];
            cableDelay <= 9'h0a5 + 9'(f);
            cable_run({1'b0, f[1:0], 4'h0, 9'h0a5 + 9'(f)}, 16'hffff, 1'b1);
        end
        partnerSilenced <= 1'b0;
        cable_run(16'h6000, 16'he000, 1'b0);
        wreg(REG_INTERRUPT_CS, 16'h0100);
        pulse(8'h01);
        chk("irqActiveLow", 16'h0000, {15'h0, irqOut});
        rchk("irqStatus", ME, REG_INTERRUPT_CS, 16'h0101);
        chk("irqCleared", 16'h0001, {15'h0, irqOut});
        rchk("statusCleared", ME, REG_INTERRUPT_CS, 16'h0100);
        pulse(8'h02);
        chk("irqMasked", 16'h0001, {15'h0, irqOut});
        rchk("maskedStatus", ME, REG_INTERRUPT_CS, 16'h0102);
        wreg(REG_PHY_CONTROL_TWO, 16'h0200);
        chk("irqHighIdle", 16'h0000, {15'h0, irqOut});
        pulse(8'h01);
        chk("irqActiveHigh", 16'h0001, {15'h0, irqOut});
        wreg(REG_PHY_CONTROL_ONE, 16'h0200);
        rchk("broadcastOff", BROADCAST_ADDR, REG_BASIC_CONTROL, 16'hffff);
        rchk("ctrlOneBack", ME, REG_PHY_CONTROL_ONE, 16'h0200);
        final_report();
    end
endmodule
